// ### aims_sequencer.sv
/*
  Analog input multiplexer sequencer: control bytes, frame shadow
  copies and the slot stepping state machine.
  Assumes a byte-wide register port synchronous to the converter clock
  and a converter that takes each slot for a fixed number of cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`include "aims_regs.svh"
module aims_sequencer
#(
  parameter logic [15:0] CONV_CYCLES = `AIMS_CONV_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control byte port
  input wire logic regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Converter input routing
  output logic [3:0] muxSelect,
  output logic muxEnable,
  output logic [3:0] preampGain,
  output logic slotStart,
  output logic frameStart,
  // Configuration seen by the rest of the front end
  output logic diffEnablePairN,
  output logic [2:0] remoteEnables,
  output logic [2:0] meteringEquation,
  output logic [1:0] filterLengthSelect,
  output logic [7:0] converterClockSelect
);
  import aims_pkg::*;

  aims_state_s q;
  aims_state_s d;

  // Register index codes shared by the write and read decoders
  localparam logic [3:0] IDX_FRAME = 4'h0;
  localparam logic [3:0] IDX_SEL89 = 4'h1;
  localparam logic [3:0] IDX_SEL67 = 4'h2;
  localparam logic [3:0] IDX_SEL45 = 4'h3;
  localparam logic [3:0] IDX_SEL23 = 4'h4;
  localparam logic [3:0] IDX_SEL01 = 4'h5;
  localparam logic [3:0] IDX_EQU = 4'h6;
  localparam logic [3:0] IDX_PAIR = 4'h7;
  localparam logic [3:0] IDX_CLK = 4'h8;
  localparam logic [3:0] IDX_PREAMP = 4'h9;
  localparam logic [3:0] IDX_REMOTE = 4'hA;
  localparam logic [3:0] IDX_NONE = 4'hF;
  localparam logic [3:0] NUM_SLOTS = 4'(`AIMS_NUM_SLOTS);

  // Byte address to register index; one decoder keeps writes and reads in step
  function automatic logic [3:0] regIndex(input logic [15:0] addr);
    unique case (addr)
      `AIMS_ADDR_FRAME: regIndex = IDX_FRAME;
      `AIMS_ADDR_SEL89: regIndex = IDX_SEL89;
      `AIMS_ADDR_SEL67: regIndex = IDX_SEL67;
      `AIMS_ADDR_SEL45: regIndex = IDX_SEL45;
      `AIMS_ADDR_SEL23: regIndex = IDX_SEL23;
      `AIMS_ADDR_SEL01: regIndex = IDX_SEL01;
      `AIMS_ADDR_EQU: regIndex = IDX_EQU;
      `AIMS_ADDR_PAIR: regIndex = IDX_PAIR;
      `AIMS_ADDR_CLK: regIndex = IDX_CLK;
      `AIMS_ADDR_PREAMP: regIndex = IDX_PREAMP;
      `AIMS_ADDR_REMOTE: regIndex = IDX_REMOTE;
      default: regIndex = IDX_NONE;
    endcase
  endfunction

  // Usable slot count; lengths past the last slot stop there, since no
  // selector exists beyond slot 10 and the lane index would run off the end
  function automatic logic [3:0] frameLen(input logic [3:0] field);
    frameLen = (field > NUM_SLOTS) ? NUM_SLOTS : field;
  endfunction

  // True when a code names a current pair handed to the remote link
  function automatic logic isRemote(input logic [3:0] code, input logic [7:0] rmt);
    isRemote = ((code == `AIMS_CODE_PAIR_A) && rmt[`AIMS_BIT_RMT_A]) ||
               ((code == `AIMS_CODE_PAIR_B) && rmt[`AIMS_BIT_RMT_B]) ||
               ((code == `AIMS_CODE_PAIR_C) && rmt[`AIMS_BIT_RMT_C]);
  endfunction

  // Live selectors packed slot 0 upward
  logic [43:0] liveSel;
  assign liveSel = {q.frameReg[3:0], q.sel89[7:4], q.sel89[3:0], q.sel67[7:4], q.sel67[3:0],
                    q.sel45[7:4], q.sel45[3:0], q.sel23[7:4], q.sel23[3:0],
                    q.sel01[7:4], q.sel01[3:0]};

  // Per-slot code and remote flag out of the shadow copy, one lane per slot
  wire logic [3:0] slotCode [`AIMS_NUM_SLOTS];
  wire logic [`AIMS_NUM_SLOTS-1:0] slotRemote;
  genvar gi;
  generate
    for (gi = 0; gi < `AIMS_NUM_SLOTS; gi++)
    begin : g_slot
      assign slotCode[gi] = q.selShadow[gi*4 +: 4];
      // Live enables, so a pair handed to the link mutes from its next slot
      assign slotRemote[gi] = isRemote(slotCode[gi], q.rmtReg);
    end
  endgenerate

  // Next-state logic: register writes, reads, and the slot sequencer
  always_comb
  begin
    d = q;
    d.slotStart = 1'b0;
    d.frameStart = 1'b0;
    // Byte writes land immediately; the sequencer sees shadow length and selectors but live remote enables
    if (regWrite)
    begin
      unique case (regIndex(regAddr))
        IDX_FRAME: d.frameReg = regWdata;
        IDX_SEL89: d.sel89 = regWdata;
        IDX_SEL67: d.sel67 = regWdata;
        IDX_SEL45: d.sel45 = regWdata;
        IDX_SEL23: d.sel23 = regWdata;
        IDX_SEL01: d.sel01 = regWdata;
        IDX_EQU: d.equReg = regWdata;
        IDX_PAIR: d.pairReg = regWdata;
        IDX_CLK: d.clkReg = regWdata;
        IDX_PREAMP: d.preReg = regWdata;
        IDX_REMOTE: d.rmtReg = regWdata;
        default: d.frameReg = q.frameReg; // Unmapped bytes ignore writes
      endcase
    end
    // Read data registered; unmapped bytes read zero
    unique case (regIndex(regAddr))
      IDX_FRAME: d.rdData = q.frameReg;
      IDX_SEL89: d.rdData = q.sel89;
      IDX_SEL67: d.rdData = q.sel67;
      IDX_SEL45: d.rdData = q.sel45;
      IDX_SEL23: d.rdData = q.sel23;
      IDX_SEL01: d.rdData = q.sel01;
      IDX_EQU: d.rdData = q.equReg;
      IDX_PAIR: d.rdData = q.pairReg;
      IDX_CLK: d.rdData = q.clkReg;
      IDX_PREAMP: d.rdData = q.preReg;
      IDX_REMOTE: d.rdData = q.rmtReg;
      default: d.rdData = `AIMS_RESET_BYTE;
    endcase
    // Slot sequencer
    unique case (q.state)
      AIMS_IDLE:
      begin
        // A zero frame length parks the multiplexer, which is what lets
        // software rewrite the selectors safely
        d.muxEn = 1'b0;
        if (q.frameReg[7:4] != 4'h0)
        begin
          d.lenShadow = frameLen(q.frameReg[7:4]);
          d.selShadow = liveSel;
          d.slot = 4'h0;
          d.state = AIMS_NEXT;
          d.frameStart = 1'b1;
        end
      end
      AIMS_NEXT:
      begin
        d.muxSel = slotCode[q.slot];
        // Pairs remote when their slot is routed are kept off the local converter
        d.muxEn = !slotRemote[q.slot];
        d.convCnt = CONV_CYCLES;
        d.slotStart = 1'b1;
        d.state = AIMS_CONV;
      end
      AIMS_CONV:
      begin
        if (q.convCnt > 16'h0001)
        begin
          d.convCnt = q.convCnt - 16'h0001;
        end
        else if (q.slot + 4'h1 < q.lenShadow)
        begin
          d.slot = q.slot + 4'h1;
          d.state = AIMS_NEXT;
        end
        else
        begin
          // Frame done; the next one picks up any new settings
          d.state = AIMS_IDLE;
          d.muxEn = 1'b0;
        end
      end
      default: d.state = AIMS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs
  assign regRdata = q.rdData;
  assign muxSelect = q.muxSel;
  assign muxEnable = q.muxEn;
  assign slotStart = q.slotStart;
  assign frameStart = q.frameStart;
  // Gain sits ahead of the multiplexer on the first pair, so it follows the bit alone
  assign preampGain = q.preReg[`AIMS_BIT_PREAMP] ? `AIMS_GAIN_HIGH : `AIMS_GAIN_UNITY;
  assign diffEnablePairN = q.pairReg[`AIMS_BIT_DIFF_N];
  assign remoteEnables = q.rmtReg[`AIMS_BIT_RMT_C:`AIMS_BIT_RMT_A];
  assign meteringEquation = q.equReg[7:5];
  assign filterLengthSelect = q.pairReg[2:1];
  assign converterClockSelect = q.clkReg;
endmodule
`default_nettype wire

// ### aims_regs.svh
/*
  Register offsets, field positions, reset values and selector codes
  for the analog input multiplexer sequencer.
  Assumes the control bytes sit on a byte-wide memory-mapped port.
*/
`ifndef AIMS_REGS_SVH
`define AIMS_REGS_SVH
`define AIMS_ADDR_FRAME 16'h2100
`define AIMS_ADDR_SEL89 16'h2101
`define AIMS_ADDR_SEL67 16'h2102
`define AIMS_ADDR_SEL45 16'h2103
`define AIMS_ADDR_SEL23 16'h2104
`define AIMS_ADDR_SEL01 16'h2105
`define AIMS_ADDR_EQU 16'h2106
`define AIMS_ADDR_PAIR 16'h210C
`define AIMS_ADDR_CLK 16'h2200
`define AIMS_ADDR_PREAMP 16'h2704
`define AIMS_ADDR_REMOTE 16'h2709
`define AIMS_RESET_BYTE 8'h00
`define AIMS_BIT_PREAMP 5
`define AIMS_BIT_RMT_A 3
`define AIMS_BIT_RMT_B 4
`define AIMS_BIT_RMT_C 5
`define AIMS_BIT_DIFF_N 4
`define AIMS_BIT_DIFF_A 5
`define AIMS_BIT_DIFF_B 6
`define AIMS_BIT_DIFF_C 7
`define AIMS_EQU_SUM3 3'h5
`define AIMS_SEL_MAX 4'hA
`define AIMS_NUM_SLOTS 11
`define AIMS_GAIN_HIGH 4'h8
`define AIMS_GAIN_UNITY 4'h1
`define AIMS_CODE_PAIR_A 4'h2
`define AIMS_CODE_PAIR_B 4'h4
`define AIMS_CODE_PAIR_C 4'h6
`define AIMS_CONV_CYCLES 16'h0010
`endif

// ### aims_pkg.sv
/*
  Types for the analog input multiplexer sequencer.
  Assumes aims_regs.svh is available on the include path.
*/
package aims_pkg;
  typedef enum logic [1:0] {
    AIMS_IDLE = 2'b00,
    AIMS_CONV = 2'b01,
    AIMS_NEXT = 2'b10
  } aims_state_e;

  typedef struct packed {
    aims_state_e state;
    logic [7:0] frameReg;
    logic [7:0] sel89;
    logic [7:0] sel67;
    logic [7:0] sel45;
    logic [7:0] sel23;
    logic [7:0] sel01;
    logic [7:0] equReg;
    logic [7:0] pairReg;
    logic [7:0] clkReg;
    logic [7:0] preReg;
    logic [7:0] rmtReg;
    logic [43:0] selShadow;
    logic [3:0] lenShadow;
    logic [3:0] slot;
    logic [15:0] convCnt;
    logic [3:0] muxSel;
    logic muxEn;
    logic [7:0] rdData;
    logic slotStart;
    logic frameStart;
  } aims_state_s;
endpackage

// ### aims_sequencer_asserts.sv
/* Checker for the sequencer ports: register echo, field outputs, slot timing.
   Assumes it is bound into every sequencer instance. */
`timescale 1ns/10ps
`default_nettype none
module aims_sequencer_chk
#(
  parameter logic [15:0] CONV_CYCLES = 16'h0010
)
(
  // Clock, reset and register port
  input wire logic clock, sys_rst, regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata, regRdata, converterClockSelect,
  // Routing and configuration outputs
  input wire logic [3:0] muxSelect, preampGain,
  input wire logic muxEnable, slotStart, frameStart, diffEnablePairN,
  input wire logic [2:0] remoteEnables, meteringEquation,
  input wire logic [1:0] filterLengthSelect
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [15:0] gapQ;
  // Cycles since the last slot began; a stuck counter in the design shows here
  always_ff @(posedge clock)
  begin
    gapQ <= (sys_rst || slotStart) ? 16'h0000 : gapQ + 16'h0001;
  end
  a_slot_after_frame: assert property (frameStart |=> slotStart && !frameStart)
    else $error("slot 0 did not follow frame start");
  a_slot_period: assert property (slotStart && !$past(frameStart) |-> gapQ == CONV_CYCLES)
    else $error("slot period wrong");
  // Remote enables as they stood when the slot's routing was chosen
  logic [2:0] rmtPastQ;
  logic remoteCode;
  always_ff @(posedge clock)
  begin
    rmtPastQ <= remoteEnables;
  end
  assign remoteCode = (rmtPastQ[0] && muxSelect == 4'h2) ||
                      (rmtPastQ[1] && muxSelect == 4'h4) ||
                      (rmtPastQ[2] && muxSelect == 4'h6);
  a_gain_value: assert property (regWrite && regAddr == 16'h2704 |=>
    preampGain == ((($past(regWdata) & 8'h20) != 8'h00) ? 4'h8 : 4'h1))
    else $error("preamp gain wrong");
  a_remote_bits: assert property (regWrite && regAddr == 16'h2709 |=>
    {2'b00, remoteEnables, 3'b000} == ($past(regWdata) & 8'h38))
    else $error("remote enables wrong");
  a_equ_field: assert property (regWrite && regAddr == 16'h2106 |=>
    {meteringEquation, 5'h00} == ($past(regWdata) & 8'hE0))
    else $error("equation field wrong");
  a_diff_bit: assert property (regWrite && regAddr == 16'h210C |=>
    diffEnablePairN == (($past(regWdata) & 8'h10) != 8'h00))
    else $error("pairing bit wrong");
  a_filter_len: assert property (regWrite && regAddr == 16'h210C |=>
    {5'h00, filterLengthSelect, 1'b0} == ($past(regWdata) & 8'h06))
    else $error("filter length field wrong");
  a_clock_select: assert property (regWrite && regAddr == 16'h2200 |=>
    converterClockSelect == $past(regWdata))
    else $error("converter clock byte wrong");
  a_remote_mute: assert property (slotStart && remoteCode |-> !muxEnable)
    else $error("remote pair drove converter");
  a_local_drive: assert property (slotStart && !remoteCode |-> muxEnable)
    else $error("local input not routed");
  a_read_back: assert property (regWrite && regAddr == 16'h2105 ##1 $stable(regAddr)
    |=> regRdata == $past(regWdata, 2))
    else $error("selector byte read back wrong");
  // Main scenarios reached
  c_frame: cover property (frameStart);
  c_mute: cover property (slotStart && !muxEnable);
  c_gain: cover property (preampGain == 4'h8);
endmodule
bind aims_sequencer aims_sequencer_chk #(.CONV_CYCLES(CONV_CYCLES)) aims_sequencer_chk_i (
  .clock(clock), .sys_rst(sys_rst), .regWrite(regWrite), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .converterClockSelect(converterClockSelect),
  .muxSelect(muxSelect), .preampGain(preampGain), .muxEnable(muxEnable),
  .slotStart(slotStart), .frameStart(frameStart), .diffEnablePairN(diffEnablePairN),
  .remoteEnables(remoteEnables), .meteringEquation(meteringEquation),
  .filterLengthSelect(filterLengthSelect));
`default_nettype wire

// ### aims_sequencer_tb.sv
/* Self-checking bench for the sequencer: registers, frames, slot order.
   Assumes a short conversion count so frames stay brief. */
`timescale 1ns/10ps
`default_nettype none
module aims_sequencer_tb;
  logic clock = 1'b0, sys_rst = 1'b1, regWrite = 1'b0;
  logic [15:0] regAddr = 16'h0000, a;
  logic [7:0] regWdata = 8'h00, regRdata, converterClockSelect, d;
  logic [3:0] muxSelect, preampGain, len;
  logic muxEnable, slotStart, frameStart, diffEnablePairN;
  logic [2:0] remoteEnables, meteringEquation;
  logic [1:0] filterLengthSelect;
  logic [15:0] addrs [11] = '{16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104,
    16'h2105, 16'h2106, 16'h210C, 16'h2200, 16'h2704, 16'h2709};
  logic [3:0] sel [11];
  int err_count = 0, num_checks = 0;
  aims_sequencer #(.CONV_CYCLES(16'h0002)) aims_sequencer_i (.clock(clock),
    .sys_rst(sys_rst), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .muxSelect(muxSelect), .muxEnable(muxEnable),
    .preampGain(preampGain), .slotStart(slotStart), .frameStart(frameStart),
    .diffEnablePairN(diffEnablePairN), .remoteEnables(remoteEnables),
    .meteringEquation(meteringEquation), .filterLengthSelect(filterLengthSelect),
    .converterClockSelect(converterClockSelect));
  // 50 MHz clock
  initial forever #10 clock = ~clock;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wr(logic [15:0] ad, logic [7:0] dt);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= ad;
    regWdata <= dt;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // Read data is registered, so it is looked at one edge after the address
  task automatic rd(logic [15:0] ad, logic [7:0] e);
    @(posedge clock);
    regAddr <= ad;
    @(posedge clock);
    @(negedge clock);
    chk("read", e, regRdata);
  endtask
  // Next slot or frame pulse, bounded so a silent sequencer cannot hang here
  task automatic nxt(logic [1:0] e);
    for (int k = 0; k < 100; k++)
    begin
      @(negedge clock);
      if (slotStart || frameStart) break;
    end
    chk("pulse", {6'h00, e}, {6'h00, frameStart, slotStart});
  endtask
  // Pair A is the only remote pair in the frame test
  function automatic logic [7:0] en_exp(logic [3:0] c);
    return {7'h00, c != 4'h2};
  endfunction
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'h7fb5));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(16'h2300, 8'h00);
    chk("gain", 8'h01, {4'h0, preampGain});
    repeat (20)
    begin
      a = addrs[$urandom_range(10)];
      d = $urandom;
      wr(a, d);
      rd(a, d);
      if (a == 16'h2200) chk("clksel", d, converterClockSelect);
      if (a == 16'h210C) chk("firlen", {6'h00, d[2:1]}, {6'h00, filterLengthSelect});
    end
    // Length held at zero while the rest is set; let any running frame end
    wr(16'h2100, 8'h00);
    repeat (60) @(posedge clock);
    wr(16'h2709, 8'h08);
    wr(16'h2704, 8'h20);
    wr(16'h2106, 8'hA0);
    wr(16'h210C, 8'h10);
    @(negedge clock);
    chk("gain", 8'h08, {4'h0, preampGain});
    chk("equ", 8'h05, {5'h00, meteringEquation});
    foreach (sel[i]) sel[i] = $urandom_range(10);
    sel[0] = 4'h2;
    sel[1] = 4'h0;
    len = 4'h3 + $urandom_range(8);
    // Length goes first, then the selectors; frames already running keep old codes
    wr(16'h2100, {len, sel[10]});
    for (int i = 1; i < 10; i += 2) wr(16'h2105 - 16'(i / 2), {sel[i], sel[i - 1]});
    // Skip any frame launched on the length write; the next one sees every selector
    @(negedge clock);
    for (int k = 0; k < 100; k++)
    begin
      @(negedge clock);
      if (frameStart) break;
    end
    for (int f = 0; f < 2; f++)
    begin
      if (f > 0) nxt(2'b10);
      else chk("frame", 8'h02, {6'h00, frameStart, slotStart});
      for (int n = 0; n < len; n++)
      begin
        nxt(2'b01);
        chk("sel", {4'h0, sel[n]}, {4'h0, muxSelect});
        chk("en", en_exp(sel[n]), {7'h00, muxEnable});
        if (f == 0 && n == 0) wr(16'h2105, 8'h89);
      end
      sel[0] = 4'h9;
      sel[1] = 4'h8;
    end
    close_out();
  end
endmodule
`default_nettype wire
